// File: sdrb_pkg.sv
// sdrb_pkg: constants and carrier types of the synthesizer divider register bank
package sdrb_pkg;

    // serial word and target selector
    localparam int          WORD_W        = 32;
    localparam int          SEL_W         = 4;
    localparam int          UPPER_W       = WORD_W - SEL_W;
    localparam logic [3:0]  SEL_INTEGER   = 4'h0;
    localparam logic [3:0]  SEL_PRIMARY   = 4'h1;
    localparam logic [3:0]  SEL_AUXILIARY = 4'h2;
    localparam logic [3:0]  SEL_PHASE     = 4'h3;
    localparam logic [3:0]  SEL_FIRST_EXT = 4'h4;
    localparam logic [3:0]  SEL_LAST      = 4'hc;
    localparam logic [3:0]  SEL_REF_PUMP  = 4'h4;
    localparam logic [3:0]  SEL_OUTPUT    = 4'h6;
    localparam int          EXT_N         = 9;

    // integer / prescaler / band search word
    localparam int INT_LSB      = 4;
    localparam int INT_W        = 16;
    localparam int PRESCALE_BIT = 20;
    localparam int BAND_BIT     = 21;

    // fraction, modulus and phase words
    localparam int FRAC_LSB     = 4;
    localparam int FRAC_W       = 24;
    localparam int AUXILIARY_FRACTION_NUMERATOR_LSB    = 18;
    localparam int AUXILIARY_FRACTION_NUMERATOR_W      = 14;
    localparam int AUXILIARY_MODULUS_LSB     = 4;
    localparam int AUXILIARY_MODULUS_W       = 14;
    localparam int PHASE_LSB    = 4;
    localparam int PHASE_W      = 24;
    localparam int ADJUST_BIT   = 28;
    localparam int RESYNC_BIT   = 29;
    localparam int INHIBIT_BIT  = 30;

    // output divider select and its buffer mode (full-word positions)
    localparam int DIVBUF_BIT   = 14;
    localparam int DIVSEL_LSB   = 21;
    localparam int DIVSEL_W     = 3;

    // configuration in force in the synthesizer core
    typedef struct packed {
        logic [INT_W-1:0]    int_value;
        logic                prescaler_select;
        logic                band_search_bit;
        logic [FRAC_W-1:0]   primary_fraction_numerator;
        logic [AUXILIARY_FRACTION_NUMERATOR_W-1:0]  auxiliary_fraction_numerator;
        logic [AUXILIARY_MODULUS_W-1:0]   auxiliary_modulus;
        logic [PHASE_W-1:0]  phase_value;
        logic                modulator_reset_inhibit;
        logic                phase_resync;
        logic                phase_adjust;
        logic [DIVSEL_W-1:0] divider_select;
    } sdrb_cfg_type;

    localparam sdrb_cfg_type CFG_RESET = '0;

endpackage : sdrb_pkg

// File: sdrb_register_bank.sv
// sdrb_register_bank: three-wire loaded, write-only latch bank with commit on the integer word
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
module sdrb_register_bank
    import sdrb_pkg::*;
(
    input  wire logic                       mclk,                 // core clock, 20 MHz
    input  wire logic                       rst,                  // synchronous reset, high
    input  wire logic                       serial_clock,         // link clock from host
    input  wire logic                       serial_data,          // serial data from host
    input  wire logic                       transfer_strobe,      // load strobe from host
    output sdrb_cfg_type                    cfg,                  // configuration in force
    output logic [EXT_N-1:0][UPPER_W-1:0]   ext_latch,            // latches 4 to 12, upper bits
    output logic                            band_search_start,    // pulse: start band search
    output logic                            modulator_reset,      // pulse: reset modulator
    output logic                            word_loaded,          // pulse: a word was decoded
    output logic [SEL_W-1:0]                loaded_selector       // selector of last word
);

    ////////////////////////////////////////////////////////////////////////////
    // state types of the two domains

    typedef struct packed {
        logic [WORD_W-1:0] shift;
    } sdrb_link_type;

    typedef struct packed {
        logic [2:0]                       sync;
        logic                             seen;
        logic                             load;
        logic [WORD_W-1:0]                word;
        logic [FRAC_W-1:0]                hold_frac;
        logic [AUXILIARY_FRACTION_NUMERATOR_W-1:0]               hold_auxiliary_fraction_numerator;
        logic [AUXILIARY_MODULUS_W-1:0]                hold_auxiliary_modulus;
        logic [PHASE_W-1:0]               hold_phase;
        logic [EXT_N-1:0][UPPER_W-1:0]    ext;
        sdrb_cfg_type                     cfg;
        logic                             band_start;
        logic                             mod_reset;
        logic                             loaded;
        logic [SEL_W-1:0]                 sel;
    } sdrb_core_type;

    sdrb_link_type link;
    sdrb_link_type next_link;
    sdrb_core_type core;
    sdrb_core_type next_core;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // upper bits of a word, stored in the plain latches
    function automatic logic [UPPER_W-1:0] upper_bits(input logic [WORD_W-1:0] w);
        upper_bits = w[WORD_W-1:SEL_W];
    endfunction

    // array slot of a plain latch selector
    function automatic logic [SEL_W-1:0] ext_slot(input logic [SEL_W-1:0] s);
        ext_slot = s - SEL_FIRST_EXT;
    endfunction

    // bit of a plain latch, addressed by its full-word position
    function automatic logic ext_bit(input logic [UPPER_W-1:0] v, input int pos);
        ext_bit = v[pos-SEL_W];
    endfunction

    // divider select field of the output latch
    function automatic logic [DIVSEL_W-1:0] div_field(input logic [UPPER_W-1:0] v);
        div_field = v[DIVSEL_LSB-SEL_W +: DIVSEL_W];
    endfunction

    // target selector of a word, the four lowest bits
    function automatic logic [SEL_W-1:0] selector_of(input logic [WORD_W-1:0] w);
        selector_of = w[SEL_W-1:0];
    endfunction

    // buffer mode of the divider select, kept in the reference latch
    function automatic logic divider_buffered(input logic [EXT_N-1:0][UPPER_W-1:0] e);
        divider_buffered = ext_bit(e[ext_slot(SEL_REF_PUMP)], DIVBUF_BIT);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // link domain: shift register on the host's clock
    // no reset here: the host clock may stand still, and the word is only used
    // once a strobe qualifies it

    always_comb begin
        next_link = link;
        next_link.shift = {link.shift[WORD_W-2:0], serial_data};
    end

    always_ff @(posedge serial_clock) begin
        link <= next_link;
    end

    ////////////////////////////////////////////////////////////////////////////
    // core domain: strobe synchroniser, word capture, decode and commit

    always_comb begin
        logic [SEL_W-1:0]   sel;
        logic [UPPER_W-1:0] up;
        sel = core.word[SEL_W-1:0];
        up  = upper_bits(core.word);

        next_core = core;

        // three-stage strobe synchroniser; only stages two and three are judged
        next_core.sync = {core.sync[1:0], transfer_strobe};

        next_core.load       = 1'b0;
        next_core.band_start = 1'b0;
        next_core.mod_reset  = 1'b0;
        next_core.loaded     = 1'b0;

        // strobe rise captures word
        // the shift word is stable here because the host stops clocking
        // before it raises the strobe; this is the request of the crossing
        if (core.sync[1] && core.sync[2] && !core.seen) begin
            next_core.seen = 1'b1;
            next_core.load = 1'b1;
            next_core.word = link.shift;
        end else if (!core.sync[1] && !core.sync[2]) begin
            next_core.seen = 1'b0;
        end

        // decode of the captured word
        if (core.load) begin
            next_core.loaded = 1'b1;
            next_core.sel    = sel;
            if (sel == SEL_INTEGER) begin
                next_core.cfg.int_value = core.word[INT_LSB +: INT_W];
                next_core.cfg.prescaler_select = core.word[PRESCALE_BIT];
                next_core.cfg.band_search_bit  = core.word[BAND_BIT];
                next_core.band_start = core.word[BAND_BIT];
                next_core.mod_reset = !core.cfg.modulator_reset_inhibit;
                next_core.cfg.primary_fraction_numerator   = core.hold_frac;
                next_core.cfg.auxiliary_fraction_numerator = core.hold_auxiliary_fraction_numerator;
                next_core.cfg.auxiliary_modulus            = core.hold_auxiliary_modulus;
                next_core.cfg.phase_value                  = core.hold_phase;
                if (ext_bit(core.ext[ext_slot(SEL_REF_PUMP)], DIVBUF_BIT)) begin
                    next_core.cfg.divider_select = div_field(core.ext[ext_slot(SEL_OUTPUT)]);
                end
            end else if (sel == SEL_PRIMARY) begin
                next_core.hold_frac = core.word[FRAC_LSB +: FRAC_W];
            end else if (sel == SEL_AUXILIARY) begin
                next_core.hold_auxiliary_fraction_numerator = core.word[AUXILIARY_FRACTION_NUMERATOR_LSB +: AUXILIARY_FRACTION_NUMERATOR_W];
                next_core.hold_auxiliary_modulus = core.word[AUXILIARY_MODULUS_LSB +: AUXILIARY_MODULUS_W];
            end else if (sel == SEL_PHASE) begin
                // phase value waits; the control bits act at once
                next_core.hold_phase = core.word[PHASE_LSB +: PHASE_W];
                next_core.cfg.modulator_reset_inhibit = core.word[INHIBIT_BIT];
                next_core.cfg.phase_resync            = core.word[RESYNC_BIT];
                next_core.cfg.phase_adjust            = core.word[ADJUST_BIT];
            end else if (sel <= SEL_LAST) begin
                next_core.ext[ext_slot(sel)] = up;
                if (sel == SEL_OUTPUT &&
                    !ext_bit(core.ext[ext_slot(SEL_REF_PUMP)], DIVBUF_BIT)) begin
                    next_core.cfg.divider_select = div_field(up);
                end
            end
            // selectors above 12 fall through and change no latch or configuration, only the reported selector
        end

        if (rst) begin
            next_core      = '0;
            // strobe may already be high at release: wait for it to fall first
            next_core.seen = 1'b1;
            next_core.cfg  = CFG_RESET;
        end
    end

    always_ff @(posedge mclk) begin
        core <= next_core;
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs, all from flip-flops

    assign cfg               = core.cfg;
    assign ext_latch         = core.ext;
    assign band_search_start = core.band_start;
    assign modulator_reset   = core.mod_reset;
    assign word_loaded       = core.loaded;
    assign loaded_selector   = core.sel;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    // link check: a bit sampled two edges ago sits one place up; each attempt starts at
    // its sampling edge, so the unreset shifter never enters the check (link has no reset)
    a_shift_msb_first: assert property (@(posedge serial_clock) disable iff (1'b0)
        1'b1 |-> ##2 (link.shift[1] == $past(serial_data, 2)))
        else $error("serial bit not shifted toward msb");

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    sequence strobe_rise_s;
        core.sync[1] && core.sync[2] && !core.seen;
    endsequence

    sequence integer_load_s;
        core.load && core.word[SEL_W-1:0] == SEL_INTEGER;
    endsequence

    sequence plain_load_s;
        core.load && selector_of(core.word) >= SEL_FIRST_EXT && selector_of(core.word) <= SEL_LAST;
    endsequence

    sequence output_load_s;
        core.load && selector_of(core.word) == SEL_OUTPUT;
    endsequence

    a_strobe_to_load: assert property (
        strobe_rise_s |=> core.load ##1 word_loaded)
        else $error("strobe rise did not load a word");

    a_integer_decode: assert property (
        integer_load_s |=> cfg.int_value == $past(core.word[INT_LSB +: INT_W])
            && cfg.prescaler_select == $past(core.word[PRESCALE_BIT]))
        else $error("integer word fields not decoded");

    a_band_search_go: assert property (
        integer_load_s ##0 core.word[BAND_BIT] |=> band_search_start ##1 !band_search_start)
        else $error("band search not started as one pulse");

    a_band_search_hold: assert property (
        !(core.load && selector_of(core.word) == SEL_INTEGER && core.word[BAND_BIT]) |=> !band_search_start)
        else $error("band search started without cause");

    a_fraction_held: assert property (
        core.load && core.word[SEL_W-1:0] == SEL_PRIMARY |=> $stable(cfg.primary_fraction_numerator))
        else $error("fraction went active before commit");

    a_fraction_commit: assert property (
        integer_load_s |=> cfg.primary_fraction_numerator == $past(core.hold_frac)
            && cfg.auxiliary_modulus == $past(core.hold_auxiliary_modulus))
        else $error("holding latches not committed");

    a_modulator_reset: assert property (
        integer_load_s |=> modulator_reset == !$past(cfg.modulator_reset_inhibit))
        else $error("modulator reset wrong for inhibit bit");

    a_unused_select: assert property (
        core.load && core.word[SEL_W-1:0] > SEL_LAST |=> $stable(ext_latch) && $stable(cfg)
            && $stable(core.hold_frac) && $stable(core.hold_phase))
        else $error("unused selector changed a latch");

    a_divider_direct: assert property (
        core.load && core.word[SEL_W-1:0] == SEL_OUTPUT
            && !ext_bit(core.ext[ext_slot(SEL_REF_PUMP)], DIVBUF_BIT)
        |=> cfg.divider_select == div_field($past(upper_bits(core.word))))
        else $error("divider select not applied directly");

    a_primary_capture: assert property (
        core.load && selector_of(core.word) == SEL_PRIMARY
        |=> core.hold_frac == $past(core.word[FRAC_LSB +: FRAC_W]))
        else $error("primary numerator not captured");

    a_aux_capture: assert property (
        core.load && selector_of(core.word) == SEL_AUXILIARY
        |=> core.hold_auxiliary_fraction_numerator == $past(core.word[AUXILIARY_FRACTION_NUMERATOR_LSB +: AUXILIARY_FRACTION_NUMERATOR_W]))
        else $error("auxiliary numerator not captured");

    a_aux_modulus: assert property (
        core.load && selector_of(core.word) == SEL_AUXILIARY
        |=> core.hold_auxiliary_modulus == $past(core.word[AUXILIARY_MODULUS_LSB +: AUXILIARY_MODULUS_W]))
        else $error("auxiliary modulus not captured");

    a_phase_held: assert property (
        core.load && selector_of(core.word) == SEL_PHASE
        |=> $stable(cfg.phase_value) && core.hold_phase == $past(core.word[PHASE_LSB +: PHASE_W]))
        else $error("phase value went active before commit");

    a_plain_latch: assert property (
        plain_load_s
        |=> ext_latch[$past(ext_slot(selector_of(core.word)))] == $past(upper_bits(core.word)))
        else $error("plain latch not loaded with upper bits");

    a_divider_buffered: assert property (
        output_load_s ##0 divider_buffered(core.ext)
        |=> $stable(cfg.divider_select))
        else $error("buffered divider select applied early");

    a_divider_commit: assert property (
        integer_load_s ##0 divider_buffered(core.ext)
        |=> cfg.divider_select == $past(div_field(core.ext[ext_slot(SEL_OUTPUT)])))
        else $error("buffered divider select not committed");

    a_reload_word: assert property (
        strobe_rise_s
        |=> core.word == $past(link.shift))
        else $error("strobe did not take the shifter word");

    a_loaded_pulse: assert property (
        word_loaded
        |=> !word_loaded)
        else $error("word loaded flag longer than one cycle");

    a_selector_report: assert property (
        core.load
        |=> loaded_selector == $past(selector_of(core.word)))
        else $error("reported selector differs from decoded word");

endmodule // sdrb_register_bank

// File: sdrb_host_model.sv
// sdrb_host_model: behavioural host driving the three-wire programming link
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
module sdrb_host_model (
    output logic serial_clock,    // link clock, still low between frames
    output logic serial_data,     // serial data to the bank
    output logic transfer_strobe  // load strobe to the bank
);
    // idle link: clock low, strobe low
    initial begin
        serial_clock    = 1'b0;
        serial_data     = 1'b0;
        transfer_strobe = 1'b0;
    end

    // msb first shifting
    // data changes while the clock is low; 30 ns link period
    task automatic shift_word(input logic [31:0] w);
        for (int i = 31; i >= 0; i--) begin
            serial_data = w[i];
            #15 serial_clock = 1'b1;
            #15 serial_clock = 1'b0;
        end
        // released line shows the inverse, so a stale bit cannot pass for a good one
        serial_data = ~w[0];
    endtask

    // strobe after shifting
    // a strobe without shifting first reloads the current word
    task automatic raise_strobe();
        #40 transfer_strobe = 1'b1;
    endtask

    // low time well above three core cycles before the next rise
    task automatic drop_strobe();
        #300 transfer_strobe = 1'b0;
        #300;
    endtask
endmodule // sdrb_host_model

// File: tb.sv
// tb: self-checking bench of the synthesizer divider register bank
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
module tb;
    import sdrb_pkg::*;

    logic                          mclk;
    logic                          rst;
    wire                           serial_clock;
    wire                           serial_data;
    wire                           transfer_strobe;
    sdrb_cfg_type                  cfg;
    logic [EXT_N-1:0][UPPER_W-1:0] ext_latch;
    logic                          band_search_start;
    logic                          modulator_reset;
    logic                          word_loaded;
    logic [SEL_W-1:0]              loaded_selector;
    logic                          got_bs;
    logic                          got_mr;
    int                            miscompares;
    int                            comparisons;

    sdrb_register_bank i_sdrb_register_bank (.mclk(mclk), .rst(rst), .serial_clock(serial_clock),
        .serial_data(serial_data), .transfer_strobe(transfer_strobe), .cfg(cfg), .ext_latch(ext_latch),
        .band_search_start(band_search_start), .modulator_reset(modulator_reset),
        .word_loaded(word_loaded), .loaded_selector(loaded_selector));

    sdrb_host_model i_sdrb_host_model (.serial_clock(serial_clock), .serial_data(serial_data),
        .transfer_strobe(transfer_strobe));

    // 20 MHz core clock
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////////////////////
    // verdict, compare and load helpers
    task automatic print_verdict();
        $display("counts: comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // pulses stand one cycle, so they are captured in the word_loaded cycle
    task automatic wait_loaded();
        bit done;
        done = 0;
        for (int n = 0; n < 40 && !done; n++) begin
            @(posedge mclk);
            #1;
            if (word_loaded === 1'b1) begin
                done   = 1;
                got_bs = band_search_start;
                got_mr = modulator_reset;
            end
        end
        if (!done) begin
            miscompares++;
            $display("BAD at %0t got %h exp %h", $time, 1'b0, 1'b1);
            print_verdict();
        end
    endtask

    task automatic load(input logic [31:0] w);
        i_sdrb_host_model.shift_word(w);
        i_sdrb_host_model.raise_strobe();
        wait_loaded();
        i_sdrb_host_model.drop_strobe();
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic test_reset();
        check(32'(cfg.int_value), 32'h0);
        check(32'(ext_latch[0]), 32'h0);
        $display("test reset done");
    endtask

    task automatic test_integer();
        load(32'h0031_2340);
        check(32'(cfg.int_value), 32'h1234);
        check(32'(cfg.prescaler_select), 32'h1);
        check(32'(cfg.band_search_bit), 32'h1);
        check(32'(got_bs), 32'h1);
        check(32'(got_mr), 32'h1);
        check(32'(loaded_selector), 32'h0);
        $display("test integer done");
    endtask

    // host keeps reserved zero and fraction below modulus
    task automatic test_holding();
        load(32'h0abc_def1);
        load(32'h1556_aaa2);
        load(32'h4123_4563);
        check(32'(cfg.primary_fraction_numerator), 32'h0);
        check(32'(cfg.auxiliary_modulus), 32'h0);
        check(32'(cfg.phase_value), 32'h0);
        check(32'(cfg.modulator_reset_inhibit), 32'h1);
        // band search toggled off for this update
        load(32'h0010_4b00);
        check(32'(cfg.band_search_bit), 32'h0);
        check(32'(got_bs), 32'h0);
        check(32'(got_mr), 32'h0);
        check(32'(cfg.int_value), 32'h04b0);
        check(32'(cfg.primary_fraction_numerator), 32'habcdef);
        check(32'(cfg.auxiliary_fraction_numerator), 32'h555);
        check(32'(cfg.auxiliary_modulus), 32'h2aaa);
        check(32'(cfg.phase_value), 32'h123456);
        $display("test holding done");
    endtask

    // latches 4..12, then the unused selectors
    task automatic test_ext();
        for (int s = 4; s <= 12; s++) load({4'(s), 24'h5a5a00 + 24'(s), 4'(s)});
        for (int s = 4; s <= 12; s++) check(32'(ext_latch[s-4]), {4'h0, 4'(s), 24'h5a5a00 + 24'(s)});
        check(32'(cfg.divider_select), 32'h5);
        for (int s = 13; s <= 15; s++) begin
            load({28'hfffffff, 4'(s)});
            check(32'(loaded_selector), 32'(s));
        end
        for (int s = 4; s <= 12; s++) check(32'(ext_latch[s-4]), {4'h0, 4'(s), 24'h5a5a00 + 24'(s)});
        check(32'(cfg.divider_select), 32'h5);
        check(32'(cfg.int_value), 32'h04b0);
        $display("test ext done");
    endtask

    // phase control bits act at once; buffered divider select waits for the integer word
    task automatic test_divider();
        load(32'h0000_4004);
        load(32'h1000_0003);
        check(32'(cfg.phase_adjust), 32'h1);
        check(32'(cfg.modulator_reset_inhibit), 32'h0);
        load(32'h2000_0003);
        check(32'(cfg.phase_resync), 32'h1);
        check(32'(cfg.phase_adjust), 32'h0);
        load(32'h0060_0006);
        check(32'(cfg.divider_select), 32'h5);
        load(32'h0010_4b00);
        check(32'(cfg.divider_select), 32'h3);
        check(32'(got_mr), 32'h1);
        check(32'(cfg.phase_value), 32'h0);
        check(32'(ext_latch[2]), 32'h0060000);
        $display("test divider done");
    endtask

    // strobe alone reloads the word still in the shifter
    task automatic test_bare();
        load(32'h0123_4567);
        load(32'h0fed_cba8);
        check(32'(ext_latch[3]), 32'h0123456);
        // mid-run reset clears the latches but not the unreset link shifter
        @(posedge mclk);
        #1 rst = 1'b1;
        repeat (6) @(posedge mclk);
        #1 rst = 1'b0;
        repeat (5) @(posedge mclk);
        check(32'(ext_latch[4]), 32'h0);
        check(32'(loaded_selector), 32'h0);
        i_sdrb_host_model.raise_strobe();
        wait_loaded();
        i_sdrb_host_model.drop_strobe();
        check(32'(loaded_selector), 32'h8);
        check(32'(ext_latch[4]), 32'h0fedcba);
        check(32'(ext_latch[3]), 32'h0);
        $display("test bare done");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        rst         = 1'b1;
        got_bs      = 1'b0;
        got_mr      = 1'b0;
        miscompares = 0;
        comparisons = 0;
        repeat (6) @(posedge mclk);
        #1 rst = 1'b0;
        repeat (5) @(posedge mclk);
        test_reset();
        test_integer();
        test_holding();
        test_ext();
        test_divider();
        test_bare();
        print_verdict();
    end
endmodule // tb
